// ---- verilog/vfdm_defs.svh ----
// constants for the multiplexed vacuum-fluorescent display controller
// assumes a 100 MHz system clock and a nominal internal scan oscillator rate
//
// Function
// - with chip select low, shift clock and data are ignored entirely
// - shift register moves one place per shift-clock rising edge while selected
// - data is positive logic, sampled at the shift-clock rising edge
// - duty select high scans two grids, low scans three grids
// - role select high means master, low means slave
// - 32 anode lines are shared over the active grids
// - slave anode on-time follows the external brightness pulse
// - master ignores brightness input; internal 10-bit value sets pulse width
// - master ignores phase-sync inputs; slave takes them from a master
// - master drives its dimming pulse on the brightness pulse output
// - master drives two phase-sync outputs naming the active grid during its on-time, 00 while dark
// - grid strobes are active low
// - payload first, function code last; chip select fall loads latches
// - code 0 loads all grid latches, 1 to 3 one latch, 4 dimming
// - dimming value sent lsb first, on-time value/1024, capped at 1016
// - slave sync 00 none, 01/10/11 latch one/two/three; grid, sync and pulse outputs parked
`ifndef VFDM_DEFS_SVH
`define VFDM_DEFS_SVH

`define VFDM_CLK_MHZ        100
`define VFDM_OSC_KHZ        2000
`define VFDM_OSC_PER_BIT    4
`define VFDM_BIT_CYC        (`VFDM_OSC_PER_BIT * `VFDM_CLK_MHZ * 1000 / `VFDM_OSC_KHZ)
`define VFDM_PHASE_BITS     1024
`define VFDM_DIM_MAX        10'h3f8
`define VFDM_SR_W           35
`define VFDM_CODE_POS       32
`define VFDM_DIM_POS        22
`define VFDM_SR_RST         35'h0
`define VFDM_PAT_RST        32'h0
`define VFDM_DIM_RST        10'h0
`define VFDM_CODE_ALL       3'h0
`define VFDM_CODE_G1        3'h1
`define VFDM_CODE_G3        3'h3
`define VFDM_CODE_DIM       3'h4
`define VFDM_GRID_OFF       3'h7

`endif

// ---- verilog/vfdm_pkg.sv ----
// types shared by the display controller
// assumes vfdm_defs.svh is available on the include path
`default_nettype none

package vfdm_pkg;

   typedef struct packed {
      logic chip_select;
      logic shift_clock;
      logic serial_data;
   } vfdm_serial_type;

   typedef enum logic [2:0] {
      PH_G1 = 3'b001,
      PH_G2 = 3'b010,
      PH_G3 = 3'b100
   } vfdm_phase_type;

endpackage

`default_nettype wire

// ---- verilog/vfdm_ctrl.sv ----
// multiplexed display controller: serial loader, scan timer, dimming, master/slave
// assumes all pin inputs are asynchronous to clk and are slow against it
`timescale 1ns/1ps
`default_nettype none
`include "vfdm_defs.svh"

module vfdm_ctrl (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   // three-wire serial port
   input  wire vfdm_pkg::vfdm_serial_type serial_in,
   // configuration straps
   input  wire logic                      duty_select,
   input  wire logic                      role_select,
   // slave inputs from a master
   input  wire logic                      brightness_pulse_in,
   input  wire logic [1:0]                phase_sync_in,
   // display drive
   output logic [31:0]                    anode_drive_out,
   output logic [2:0]                     digit_strobe_out,
   // master outputs toward a slave
   output logic                           brightness_pulse_out,
   output logic [1:0]                     phase_sync_out
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   localparam int PINS = 8;

   logic [PINS-1:0] pin_raw;
   logic [PINS-1:0] s1_ff;
   logic [PINS-1:0] s2_ff;
   logic [PINS-1:0] s3_ff;
   logic [PINS-1:0] flt_ff;
   logic [1:0]      flt_d_ff;

   assign pin_raw = {phase_sync_in, brightness_pulse_in, role_select, duty_select,
                     serial_in.serial_data, serial_in.shift_clock, serial_in.chip_select};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= pin_raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // a bit only moves once the last two stages agree, which rejects a lone glitch
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flt_ff   <= '0;
         flt_d_ff <= '0;
      end else begin
         for (int i = 0; i < PINS; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               flt_ff[i] <= s3_ff[i];
            end
         end
         // only chip select and shift clock need edge detection
         flt_d_ff <= flt_ff[1:0];
      end
   end

   logic       cs_f;
   logic       sd_f;
   logic       duty_f;
   logic       role_f;
   logic       bp_f;
   logic [1:0] psync_f;
   logic       cs_rise;
   logic       cs_fall;
   logic       sclk_rise;

   assign cs_f      = flt_ff[0];
   assign sd_f      = flt_ff[2];
   assign duty_f    = flt_ff[3];
   assign role_f    = flt_ff[4];
   assign bp_f      = flt_ff[5];
   assign psync_f   = flt_ff[7:6];
   assign cs_rise   = flt_ff[0] & ~flt_d_ff[0];
   assign cs_fall   = ~flt_ff[0] & flt_d_ff[0];
   assign sclk_rise = flt_ff[1] & ~flt_d_ff[1];

   // ------------------------------------------------------------
   // serial shift register and load strobe
   // ------------------------------------------------------------
   logic [`VFDM_SR_W-1:0] shift_ff;
   logic [31:0]           latch_ff [3];
   logic [9:0]            dim_ff;
   logic [2:0]            code;

   assign code = shift_ff[`VFDM_SR_W-1:`VFDM_CODE_POS];

   // a fresh frame starts clean so a short dimming frame leaves no stale code bits
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_ff <= `VFDM_SR_RST;
      end else if (cs_rise) begin
         shift_ff <= `VFDM_SR_RST;
      end else if (cs_f && sclk_rise) begin
         shift_ff <= {sd_f, shift_ff[`VFDM_SR_W-1:1]};
      end
   end

   // latches load only on the falling chip select, never mid-frame
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int g = 0; g < 3; g++) begin
            latch_ff[g] <= `VFDM_PAT_RST;
         end
      end else if (cs_fall) begin
         for (int g = 0; g < 3; g++) begin
            if (code == `VFDM_CODE_ALL || code == 3'(g + 1)) begin
               latch_ff[g] <= shift_ff[31:0];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dim_ff <= `VFDM_DIM_RST;
      end else if (cs_fall && code == `VFDM_CODE_DIM) begin
         dim_ff <= shift_ff[`VFDM_DIM_POS +: 10];
      end
   end

   // ------------------------------------------------------------
   // bit-time divider and grid scan
   // ------------------------------------------------------------
   localparam int          BIT_CYC = `VFDM_BIT_CYC;
   localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);

   logic [15:0]             div_ff;
   logic                    bit_tick;
   logic [9:0]              bit_cnt_ff;
   logic                    grid_end;
   vfdm_pkg::vfdm_phase_type phase_ff;
   vfdm_pkg::vfdm_phase_type nxt_phase;

   assign bit_tick = (div_ff == BIT_LAST);
   assign grid_end = bit_tick && (bit_cnt_ff == 10'(`VFDM_PHASE_BITS - 1));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_ff <= 16'h0;
      end else if (bit_tick) begin
         div_ff <= 16'h0;
      end else begin
         div_ff <= div_ff + 16'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bit_cnt_ff <= 10'h0;
      end else if (bit_tick) begin
         bit_cnt_ff <= bit_cnt_ff + 10'h1;
      end
   end

   // duty changes take effect at the end of grid two, never mid-phase
   always_comb begin
      nxt_phase = phase_ff;
      case (phase_ff)
         vfdm_pkg::PH_G1: nxt_phase = vfdm_pkg::PH_G2;
         vfdm_pkg::PH_G2: nxt_phase = duty_f ? vfdm_pkg::PH_G1 : vfdm_pkg::PH_G3;
         vfdm_pkg::PH_G3: nxt_phase = vfdm_pkg::PH_G1;
         default:         nxt_phase = vfdm_pkg::PH_G1;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_ff <= vfdm_pkg::PH_G1;
      end else if (grid_end) begin
         phase_ff <= nxt_phase;
      end
   end

   // ------------------------------------------------------------
   // dimming window and output drive
   // ------------------------------------------------------------
   function automatic logic [9:0] dim_cap(input logic [9:0] v);
      dim_cap = (v > `VFDM_DIM_MAX) ? `VFDM_DIM_MAX : v;
   endfunction

   function automatic logic [1:0] grid_index(input logic [2:0] onehot);
      grid_index = onehot[2] ? 2'h2 : (onehot[1] ? 2'h1 : 2'h0);
   endfunction

   logic        lit;
   logic [1:0]  slv_idx;
   logic [31:0] nxt_anode;
   logic [2:0]  nxt_grid_n;
   logic        nxt_bright;
   logic [1:0]  nxt_sync;

   assign lit     = bit_cnt_ff < dim_cap(dim_ff);
   assign slv_idx = psync_f - 2'h1;

   always_comb begin
      nxt_anode  = 32'h0;
      nxt_grid_n = `VFDM_GRID_OFF;
      nxt_bright = 1'b0;
      nxt_sync   = 2'h0;
      if (role_f) begin
         if (lit) begin
            nxt_anode  = latch_ff[grid_index(phase_ff)];
            nxt_grid_n = ~phase_ff;
            nxt_bright = 1'b1;
            nxt_sync   = 2'(grid_index(phase_ff) + 2'h1);
         end
      end else if (psync_f != 2'h0 && bp_f) begin
         nxt_anode = latch_ff[slv_idx];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         anode_drive_out      <= 32'h0;
         digit_strobe_out     <= `VFDM_GRID_OFF;
         brightness_pulse_out <= 1'b0;
         phase_sync_out       <= 2'h0;
      end else begin
         anode_drive_out      <= nxt_anode;
         digit_strobe_out     <= nxt_grid_n;
         brightness_pulse_out <= nxt_bright;
         phase_sync_out       <= nxt_sync;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   property p_cs_low_hold;
      (!cs_f ##1 !cs_f) |-> $stable(shift_ff);
   endproperty
   a_cs_low_hold: assert property (p_cs_low_hold) else $error("shift moved while deselected");

   property p_shift_in;
      (cs_f && sclk_rise && !cs_rise) |=>
         (shift_ff == {$past(sd_f), $past(shift_ff[`VFDM_SR_W-1:1])});
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("shift register did not take data bit");

   property p_load_all;
      (cs_fall && code == `VFDM_CODE_ALL) |=>
         (latch_ff[0] == $past(shift_ff[31:0]) && latch_ff[2] == $past(shift_ff[31:0]));
   endproperty
   a_load_all: assert property (p_load_all) else $error("broadcast load missed a latch");

   property p_load_dim;
      (cs_fall && code == `VFDM_CODE_DIM) |=>
         (dim_ff == $past(shift_ff[`VFDM_DIM_POS +: 10]) && $stable(latch_ff[0]));
   endproperty
   a_load_dim: assert property (p_load_dim) else $error("dimming load wrong");

   property p_duty_two;
      (grid_end && phase_ff == vfdm_pkg::PH_G2 && duty_f) |=> (phase_ff == vfdm_pkg::PH_G1);
   endproperty
   a_duty_two: assert property (p_duty_two) else $error("two-grid scan reached third grid");

   property p_cap;
      ($past(role_f) && $past(bit_cnt_ff) >= `VFDM_DIM_MAX) |->
         (digit_strobe_out == `VFDM_GRID_OFF && anode_drive_out == 32'h0);
   endproperty
   a_cap: assert property (p_cap) else $error("drive beyond capped on-time");

   property p_grid_low;
      ($past(role_f) && $past(lit)) |->
         (digit_strobe_out == ~$past(phase_ff) && brightness_pulse_out);
   endproperty
   a_grid_low: assert property (p_grid_low) else $error("grid strobe not active low");

   property p_slave_park;
      !$past(role_f) |->
         (digit_strobe_out == `VFDM_GRID_OFF && phase_sync_out == 2'h0 && !brightness_pulse_out);
   endproperty
   a_slave_park: assert property (p_slave_park) else $error("slave outputs not parked");

   property p_slave_dim;
      (!$past(role_f) && !$past(bp_f)) |-> (anode_drive_out == 32'h0);
   endproperty
   a_slave_dim: assert property (p_slave_dim) else $error("slave anodes lit without pulse");

   property p_sync_phase;
      brightness_pulse_out |-> (phase_sync_out != 2'h0 && digit_strobe_out != `VFDM_GRID_OFF);
   endproperty
   a_sync_phase: assert property (p_sync_phase) else $error("sync out idle during pulse");

endmodule

`default_nettype wire

// ---- sim/vfdm_host_model.sv ----
// host model: drives the three-wire serial port of the display controller
// assumes one bench process calls its tasks, each entered just after a clk edge
`timescale 1ns/1ps
`default_nettype none

module vfdm_host_model (
   // pacing clock
   input  wire logic                     clk,
   // serial port toward the controller
   output var  vfdm_pkg::vfdm_serial_type ser
);
   initial begin
      ser = '0;
   end

   // half of the 80 ns shift clock; edges land 1 ns after a clk edge
   task automatic half();
      repeat (4) @(posedge clk);
      #1;
   endtask

   // payload goes out lsb first, function code last
   task automatic send_frame(input logic [34:0] word, input int n);
      ser.chip_select = 1'b1; // select raised to frame the transfer
      for (int i = 0; i < n; i++) begin
         ser.serial_data = word[i]; // bit settled a half period before the rise
         half();
         ser.shift_clock = 1'b1;
         half();
         ser.shift_clock = 1'b0;
      end
      half();
      ser.chip_select = 1'b0;
      // released line must not keep showing the last bit
      ser.serial_data = ~ser.serial_data;
      repeat (3) half();
   endtask

   // clocks and data wiggle while deselected
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         ser.serial_data = ~ser.serial_data;
         half();
         ser.shift_clock = 1'b1;
         half();
         ser.shift_clock = 1'b0;
      end
   endtask
endmodule

`default_nettype wire

// ---- sim/vfdm_ctrl_bench.sv ----
// self-checking bench for the display controller
// assumes the host model drives the serial port; straps and slave pins come from here
`timescale 1ns/1ps
`default_nettype none
`include "vfdm_defs.svh"

module vfdm_ctrl_bench;
   // ----------------------------------------
   // stimulus and wiring
   // ----------------------------------------
   localparam logic [31:0] PAT_A = 32'h1234_abcd;
   localparam logic [31:0] PAT_B = 32'hfe00_0f0f;
   localparam logic [31:0] PAT_C = 32'h8000_0001;
   localparam logic [31:0] PAT_D = 32'h5555_aaaa;
   localparam logic [1:0]  SYNC_TAB [5] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
   localparam logic        PULSE_TAB [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
   localparam logic [31:0] EXP_TAB [5] = '{PAT_A, PAT_B, PAT_C, 32'h0, 32'h0};
   localparam int          BIT_CYC = `VFDM_BIT_CYC;
   localparam int          ON_BITS = 12;

   logic                      clk = 1'b0;
   logic                      arst_n = 1'b0;
   logic                      duty_select;
   logic                      role_select;
   logic                      brightness_pulse_in;
   logic [1:0]                phase_sync_in;
   logic [31:0]               anode_drive_out;
   logic [2:0]                digit_strobe_out;
   logic                      brightness_pulse_out;
   logic [1:0]                phase_sync_out;
   vfdm_pkg::vfdm_serial_type ser;
   int                        n_errors = 0;
   int                        compares = 0;
   int                        cycles = 0;
   int                        rel_cyc = 0;

   always #5 clk = ~clk;

   vfdm_host_model u_host (.clk(clk), .ser(ser));

   vfdm_ctrl u_dut (
      .clk                  (clk),
      .arst_n               (arst_n),
      .serial_in            (ser),
      .duty_select          (duty_select),
      .role_select          (role_select),
      .brightness_pulse_in  (brightness_pulse_in),
      .phase_sync_in        (phase_sync_in),
      .anode_drive_out      (anode_drive_out),
      .digit_strobe_out     (digit_strobe_out),
      .brightness_pulse_out (brightness_pulse_out),
      .phase_sync_out       (phase_sync_out)
   );

   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask

   task automatic chk_out(input logic [31:0] a, input logic [2:0] g, input logic [1:0] s,
                          input logic p, input string what);
      chk(anode_drive_out, a, what);
      chk({29'h0, digit_strobe_out}, {29'h0, g}, what);
      chk({30'h0, phase_sync_out}, {30'h0, s}, what);
      chk({31'h0, brightness_pulse_out}, {31'h0, p}, what);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic close_out();
      $display("counts: %0d compares, %0d mismatches", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // a full scan phase is far longer than this run, so the ceiling is modest
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         $display("MISMATCH t=%0t run did not finish", $time);
         close_out();
      end
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      duty_select = 1'b1;
      role_select = 1'b1;
      brightness_pulse_in = 1'b0;
      phase_sync_in = 2'b00;
      tick(10);
      chk_out(32'h0, 3'h7, 2'h0, 1'b0, "in reset");
      arst_n = 1'b1;
      rel_cyc = cycles;
      tick(5);
      // latch three keeps the broadcast pattern, code 5 and loose clocks change nothing
      u_host.send_frame({3'h0, PAT_C}, 35);
      u_host.send_frame({3'h1, PAT_A}, 35);
      u_host.send_frame({3'h2, PAT_B}, 35);
      u_host.send_frame({3'h5, PAT_D}, 35);
      u_host.idle_clocks(40);
      tick(20);
      chk_out(32'h0, 3'h7, 2'h0, 1'b0, "dark at zero dimming");
      u_host.send_frame({22'h0, 3'h4, 10'h3ff}, 13);
      tick(20);
      chk_out(PAT_A, 3'h6, 2'h1, 1'b1, "master grid1 lit");
      brightness_pulse_in = 1'b1;
      phase_sync_in = 2'b10;
      tick(10);
      chk_out(PAT_A, 3'h6, 2'h1, 1'b1, "master slave pins");
      // count is already past one bit-time, so a value of one ends the on-time
      u_host.send_frame({22'h0, 3'h4, 10'h001}, 13);
      tick(20);
      chk_out(32'h0, 3'h7, 2'h0, 1'b0, "on-time ended");
      // the phase began at reset release, so the on-time edge lands on an exact cycle
      u_host.send_frame({22'h0, 3'h4, 10'h00c}, 13);
      tick(rel_cyc + ON_BITS * BIT_CYC - cycles);
      chk_out(PAT_A, 3'h6, 2'h1, 1'b1, "last lit cycle");
      tick(1);
      chk_out(32'h0, 3'h7, 2'h0, 1'b0, "first dark cycle");
      $display("test master done");
      role_select = 1'b0;
      for (int k = 0; k < 5; k++) begin
         phase_sync_in = SYNC_TAB[k];
         brightness_pulse_in = PULSE_TAB[k];
         tick(10);
         chk_out(EXP_TAB[k], 3'h7, 2'h0, 1'b0, "slave follow");
      end
      $display("test slave done");
      close_out();
   end
endmodule

`default_nettype wire
